// ===== hw/cam_config_regs.sv
// Camera configuration register space: inquiry registers on the bus.
// Assumes a link layer that presents one quadlet per cycle, with a start
// pulse carrying the full 48-bit address and the block quadlet count.
//
// What this block does
// - Reads of unimplemented addresses return zero
// - Writes to unimplemented addresses are discarded
// - Block reads and writes are accepted
// - Decode relative to fixed inquiry base
// - Register address is base plus byte offset
// - Bit 0 is the most significant bit
// - Reinit bit write emits a one-cycle reinit_pulse
// - Reinit bit clears itself after launch
// - Format word reports one bit per format
// - Formats 0, 1, 2 available; 3-5 reserved
// - Partial format available, still format absent
// - Frame rate ignored in partial format
`timescale 1ns/1ps
module cam_config_regs #(
  parameter int COUNT_W = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_start,
  input wire logic req_write,
  input wire logic [47:0] req_addr,
  input wire logic [COUNT_W-1:0] req_quads,
  input wire logic [31:0] wr_data,
  input wire logic wr_valid,
  input wire logic partial_format_active,
  input wire logic [2:0] frame_rate_sel,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic busy,
  output logic reinit_pulse,
  output logic [2:0] frame_rate_eff
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Full 48-bit match: any other base or offset counts as unmapped
  function automatic logic hits(input logic [47:0] addr, input logic [11:0] ofs);
    return addr == cam_regs_pkg::INQ_BASE + {36'h0, ofs};
  endfunction

  // Reserved and unmapped bits stay zero
  function automatic logic [31:0] read_word(input logic [47:0] addr, input logic reinit);
    logic [31:0] w;
    w = cam_regs_pkg::ZERO_WORD;
    if (hits(addr, cam_regs_pkg::OFS_REINIT)) begin
      w[cam_regs_pkg::REINIT_POS] = reinit;
    end else if (hits(addr, cam_regs_pkg::OFS_FMT_AVAIL)) begin
      w = cam_regs_pkg::FMT_AVAIL_VALUE;
    end
    return w;
  endfunction

  // Reads and writes get their own states so a write never emits read data
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } state_type;

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  state_type state_q, state_d;
  logic [47:0] addr_q, addr_d;
  // Quadlets still to move in this transfer
  logic [COUNT_W-1:0] left_q, left_d;
  logic busy_q, busy_d;
  logic reinit_q, reinit_d;
  logic rd_valid_q, rd_valid_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic pulse_q, pulse_d;
  logic [2:0] rate_q, rate_d;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    left_d = left_q;
    rd_valid_d = 1'b0;
    rd_data_d = cam_regs_pkg::ZERO_WORD;
    pulse_d = 1'b0;
    // Reinit bit lasts one cycle: it reads 1 only in the cycle it launches
    reinit_d = 1'b0;
    // Frame rate held at last value while partial format runs
    rate_d = partial_format_active ? rate_q : frame_rate_sel;
    case (state_q)
      ST_IDLE: begin
        // Zero count treated as a single quadlet
        if (req_start) begin
          addr_d = req_addr;
          left_d = (req_quads == '0) ? COUNT_W'(1) : req_quads;
          state_d = req_write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        // One quadlet per cycle; reads insert no wait states
        rd_valid_d = 1'b1;
        rd_data_d = read_word(addr_q, reinit_q);
        addr_d = addr_q + {36'h0, cam_regs_pkg::QUADLET_STEP};
        left_d = left_q - COUNT_W'(1);
        if (left_q == COUNT_W'(1)) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // Host paces the quadlets; idle cycles simply wait
        if (wr_valid) begin
          // Only the reinit register takes writes; all else dropped
          if (hits(addr_q, cam_regs_pkg::OFS_REINIT)
              && wr_data[cam_regs_pkg::REINIT_POS]) begin
            reinit_d = 1'b1;
            pulse_d = 1'b1;
          end
          addr_d = addr_q + {36'h0, cam_regs_pkg::QUADLET_STEP};
          left_d = left_q - COUNT_W'(1);
          if (left_q == COUNT_W'(1)) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Registered so the pin carries no decode glitch
    busy_d = (state_d != ST_IDLE);
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      addr_q <= 48'h0000_0000_0000;
      left_q <= '0;
      reinit_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
      pulse_q <= 1'b0;
      rate_q <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      left_q <= left_d;
      reinit_q <= reinit_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      pulse_q <= pulse_d;
      rate_q <= rate_d;
      busy_q <= busy_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every pin comes straight from a flop
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign busy = busy_q;
  assign reinit_pulse = pulse_q;
  assign frame_rate_eff = rate_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reinit_self_clear: assert property (@(posedge core_clk) disable iff (rst)
    reinit_pulse |=> !reinit_pulse) else $error("reinit pulse held");
  a_reinit_cause: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_WRITE && wr_valid && wr_data[cam_regs_pkg::REINIT_POS]
     && hits(addr_q, cam_regs_pkg::OFS_REINIT)) |=> reinit_pulse)
    else $error("reinit write missed");
  a_pulse_from_write: assert property (@(posedge core_clk) disable iff (rst)
    reinit_pulse |-> $past(state_q) == ST_WRITE && $past(wr_valid))
    else $error("reinit pulse without write");
  a_read_no_pulse: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_READ |=> !reinit_pulse) else $error("read launched reinit");
  a_write_other_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_WRITE && !hits(addr_q, cam_regs_pkg::OFS_REINIT)) |=> !reinit_pulse)
    else $error("stray write had effect");
  a_write_no_data: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_WRITE |=> !rd_valid) else $error("write produced read data");

  // Bit n of a register sits at vector position 31-n
  a_fmt_word_value: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_READ && hits(addr_q, cam_regs_pkg::OFS_FMT_AVAIL))
    |=> rd_valid && rd_data[31:29] == 3'h7 && rd_data[28:26] == 3'h0)
    else $error("format word wrong");
  a_fmt_partial_bit: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_READ && hits(addr_q, cam_regs_pkg::OFS_FMT_AVAIL))
    |=> rd_data[24] && !rd_data[25] && rd_data[23:0] == 24'h0)
    else $error("partial or still bit wrong");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_READ && !hits(addr_q, cam_regs_pkg::OFS_REINIT)
     && !hits(addr_q, cam_regs_pkg::OFS_FMT_AVAIL)) |=> rd_valid && rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_idle_data_zero: assert property (@(posedge core_clk) disable iff (rst)
    !rd_valid |-> rd_data == 32'h0) else $error("read data without valid");
  a_block_step: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_READ && left_q > COUNT_W'(1)) |=> addr_q == $past(addr_q) + 48'h4)
    else $error("block step not four");
  a_block_length: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_IDLE && req_start && !req_write && req_quads == COUNT_W'(3))
    |=> !rd_valid ##1 rd_valid [*3] ##1 !rd_valid) else $error("block length wrong");
  a_busy_after_start: assert property (@(posedge core_clk) disable iff (rst)
    (!busy && req_start) |=> busy) else $error("start not taken");
  a_left_nonzero: assert property (@(posedge core_clk) disable iff (rst)
    state_q != ST_IDLE |-> left_q != COUNT_W'(0)) else $error("transfer count empty");
  a_rate_frozen: assert property (@(posedge core_clk) disable iff (rst)
    partial_format_active |=> frame_rate_eff == $past(frame_rate_eff))
    else $error("rate changed in partial");
endmodule

// ===== inc/cam_regs_pkg.sv
// Constants for the camera configuration register space.
// Assumes the bus link layer delivers decoded quadlet requests on core_clk.
package cam_regs_pkg;
  localparam logic [47:0] INQ_BASE = 48'hffff_f0f0_0000;
  localparam logic [11:0] OFS_REINIT = 12'h000;
  localparam logic [11:0] OFS_FMT_AVAIL = 12'h100;
  localparam logic [11:0] QUADLET_STEP = 12'h004;
  localparam int BLOCK_MAX_QUADS = 32;
  localparam int REINIT_BIT = 0;
  // Index in MSB-first numbering: bit n sits at vector position 31-n
  localparam int REINIT_POS = 31 - REINIT_BIT;
  localparam logic [31:0] FMT_AVAIL_VALUE = 32'he100_0000;
  localparam int FMT_PARTIAL_BIT = 7;
  localparam int FMT_PARTIAL_POS = 31 - FMT_PARTIAL_BIT;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ===== dv/host_model.sv
// Host node model: issues single and block quadlet transfers.
// Assumes the bench calls xfer only after reset has been released.
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic busy,
  output logic req_start,
  output logic req_write,
  output logic [47:0] req_addr,
  output logic [5:0] req_quads,
  output logic [31:0] wr_data,
  output logic wr_valid,
  output logic tmo
);
  initial {req_start, req_write, req_addr, req_quads, wr_data, wr_valid, tmo} = '0;
  // Callers keep n within 1..32 quadlets
  task automatic xfer(input logic w, input logic [47:0] a, input int n,
                      input logic [31:0] d [32]);
    @(posedge core_clk);
    req_start <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_quads <= 6'(n);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      req_start <= 1'b0;
      wr_valid <= w;
      wr_data <= d[k];
    end
    @(posedge core_clk);
    wr_valid <= 1'b0;
    // Released data no longer shows the last quadlet
    wr_data <= ~wr_data;
    for (int i = 0; i < 60; i++) begin
      #1;
      if (!busy) break;
      @(posedge core_clk);
    end
    if (busy !== 1'b0) tmo = 1'b1;
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the camera register space.
// Assumes the host model drives requests; expected reads wait in a queue.
`timescale 1ns/1ps
module tb;
  localparam logic [47:0] B = cam_regs_pkg::INQ_BASE;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic partial_format_active = 1'b0;
  logic [2:0] frame_rate_sel = 3'h0;
  logic [2:0] frame_rate_eff, fr, nf;
  logic req_start, req_write, wr_valid, busy, rd_valid, reinit_pulse, tmo;
  logic [47:0] req_addr;
  logic [5:0] req_quads;
  logic [31:0] wr_data, rd_data, seed = 32'h3a;
  logic [31:0] wd [32];
  logic [31:0] exp_q [$];
  int bad_count, samples_checked, pulses, want_pulses;
  always #2 core_clk = ~core_clk;
  cam_config_regs dut_u (.core_clk, .rst, .req_start, .req_write, .req_addr, .req_quads,
    .wr_data, .wr_valid, .partial_format_active, .frame_rate_sel, .rd_valid, .rd_data,
    .busy, .reinit_pulse, .frame_rate_eff);
  host_model host_u (.core_clk, .busy, .req_start, .req_write, .req_addr, .req_quads,
    .wr_data, .wr_valid, .tmo);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [47:0] a, input int n);
    for (int k = 0; k < n; k++)
      exp_q.push_back(a + 48'(4 * k) == B + 48'h100 ? 32'he100_0000 : 32'h0);
    host_u.xfer(1'b0, a, n, wd);
    if (tmo === 1'b1) wrap_up();
  endtask
  task automatic wr(input logic [47:0] a, input int n);
    if (a == B && wd[0][31]) want_pulses++;
    host_u.xfer(1'b1, a, n, wd);
    if (tmo === 1'b1) wrap_up();
  endtask
  task automatic wrap_up();
    if (tmo !== 1'b0 || exp_q.size() != 0) bad_count++;
    $display("checked %0d, wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check(rd_data, exp_q.pop_front());
    end
    if (reinit_pulse === 1'b1) pulses++;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(B + 48'h100, 2);
    rd(B + 48'h0f0, 32);
    rd(B + 48'h0fc, 3);
    rd(B ^ 48'h0100_0000_0100, 1);
    $display("test reads done");
    for (int k = 0; k < 32; k++) wd[k] = rnd() | 32'h8000_0000;
    wr(B + 48'h0f8, 4);
    wr(B ^ 48'h0100_0000_0000, 1);
    wd[0] = 32'h4000_0000;
    wr(B, 1);
    wd[0] = 32'h8000_0000;
    wr(B, 2);
    repeat (4) @(posedge core_clk);
    rd(B, 1);
    rd(B + 48'h100, 1);
    repeat (4) @(posedge core_clk);
    check(32'(pulses), 32'(want_pulses));
    $display("test writes done");
    fr = 3'(rnd());
    nf = ~fr;
    frame_rate_sel <= fr;
    repeat (2) @(posedge core_clk);
    #1 check(frame_rate_eff, fr);
    @(posedge core_clk);
    partial_format_active <= 1'b1;
    @(posedge core_clk);
    frame_rate_sel <= nf;
    repeat (3) @(posedge core_clk);
    #1 check(frame_rate_eff, fr);
    @(posedge core_clk);
    partial_format_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check(frame_rate_eff, nf);
    $display("test frame rate done");
    wrap_up();
  end
endmodule
